// File: rtl/soc_osc_ctrl.sv
`timescale 1ns/10ps

// Behaviour
// R1 - frequency code 111 is 8 MHz, halving per step, 000 picks slow oscillator
// R2 - frequency select field resets to 110, giving 4 MHz
// R3 - bit 3 reads 1 on external clock, 0 on internal oscillator
// R4 - bit 3 resets to 0 with two-speed plus crystal, or fail-safe
// R5 - bit 2 shows fast oscillator stable, resets to 0
// R6 - bit 1 shows slow oscillator stable, resets to 0
// R7 - writable bit 0 picks internal oscillator when 1, resets to 0
// R8 - bit 7 reads zero and ignores writes
// R9 - crystal modes count 1024 input cycles after reset and wake-up
// R10 - execution held while the start-up count runs
// R11 - a clock source switch waits a settle delay first
// R12 - reset or wake toward internal oscillator waits a warm-up delay
// R13 - external logic clock mode starts with no start-up delay
// R14 - external logic clock mode frees the second oscillator pin
// R15 - state is kept when the input clock stops, resumes in place
// R16 - amplifier gain follows crystal mode: low, medium, high
// R17 - clock source mode comes from a three-bit configuration field
// R18 - switch waits current clock fall, holds output low, waits new rise
// R19 - fast oscillator on when code nonzero and select or two-speed set
// R20 - start-up count restarts on each event, releases on terminal cycle
module soc_osc_ctrl
  import soc_pkg::*;
#(
  parameter int WARM_CYCLES   = WARMUP_CYCLES,
  parameter int SETTLE_CYCLES = SWITCH_CYCLES
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  // configuration word and events
  input  wire soc_cfg_t          configuration_word_one,
  input  wire logic              wake_from_sleep,
  // analog oscillator side, asynchronous
  input  wire logic              oscillator_pin_in,
  input  wire logic              int_osc_phase,
  input  wire logic              fast_osc_ready,
  input  wire logic              slow_osc_ready,
  // clock control outputs
  output logic                   exec_hold,
  output logic                   clk_out_hold_low,
  output logic                   sys_clk_internal,
  output soc_freq_t              postscaler_select,
  output logic                   fast_internal_oscillator_en,
  output logic                   slow_internal_oscillator_en,
  output soc_gain_t              amp_gain,
  output logic                   oscillator_pin_out_gpio
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  // decode the frequency code into slow select and divide shift
  function automatic soc_freq_t freq_decode(input logic [2:0] code);
    soc_freq_t f;
    f.slow_select = (code == FREQ_SEL_SLOW);
    f.div_shift   = FREQ_SEL_TOP - code;
    if (code == FREQ_SEL_SLOW) begin
      f.div_shift = 3'h0;
    end
    return f;
  endfunction : freq_decode

  // crystal modes need the start-up count
  function automatic logic is_crystal(input soc_fosc_t m);
    return (m == FOSC_WATCH_XTAL) || (m == FOSC_MEDIUM_XTAL) ||
           (m == FOSC_HIGH_XTAL);
  endfunction : is_crystal

  typedef enum logic [2:0] {
    ST_RUN    = 3'b000,
    ST_SETTLE = 3'b010,
    ST_FALL   = 3'b110,
    ST_RISE   = 3'b111,
    ST_OST    = 3'b001,
    ST_WARM   = 3'b011
  } soc_state_t;

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic [SYNC_W-1:0] sync3;
  logic [SYNC_W-1:0] lvl;
  logic [SYNC_W-1:0] next_lvl;
  logic              osc_rise;
  logic              osc_fall;
  logic              int_rise;
  logic              int_fall;

  // a change counts once second and third stage agree
  always_comb begin
    for (int i = 0; i < SYNC_W; i++) begin
      next_lvl[i] = (sync2[i] == sync3[i]) ? sync3[i] : lvl[i];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      lvl   <= '0;
    end else begin
      sync1 <= {slow_osc_ready, fast_osc_ready, int_osc_phase,
                oscillator_pin_in};
      sync2 <= sync1;
      sync3 <= sync2;
      lvl   <= next_lvl;
    end
  end

  assign osc_rise = next_lvl[0] & ~lvl[0];
  assign osc_fall = ~next_lvl[0] & lvl[0];
  assign int_rise = next_lvl[1] & ~lvl[1];
  assign int_fall = ~next_lvl[1] & lvl[1];

  // ****************************************************************
  // control register and configuration
  // ****************************************************************
  soc_cfg_t   cfg;
  logic [2:0] internal_freq_select;
  logic       system_clock_select;
  logic [2:0] next_internal_freq_select;
  logic       next_scs;
  logic       ctrl_wr;

  assign ctrl_wr = wr && (addr == OSC_CTRL_ADDR);

  // R8 reserved bit
  // only the field and select bits take writes
  always_comb begin
    next_internal_freq_select = internal_freq_select;
    next_scs  = system_clock_select;
    if (ctrl_wr) begin
      next_internal_freq_select = wdata[FREQ_SEL_LSB +: 3];
      next_scs  = wdata[CLK_SEL_BIT];
    end
  end

  // R17 mode field
  // configuration word is captured while reset is held
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg  <= configuration_word_one;
      // R2 field reset value
      internal_freq_select <= FREQ_SEL_RESET;
      system_clock_select  <= CLK_SEL_RESET;
    end else begin
      internal_freq_select <= next_internal_freq_select;
      system_clock_select  <= next_scs;
    end
  end

  // ****************************************************************
  // start-up and clock switch sequencer
  // ****************************************************************
  soc_state_t  state;
  soc_state_t  next_state;
  logic [10:0] cnt;
  logic [10:0] next_cnt;
  logic        boot;
  logic        applied_int;
  logic        next_applied_int;
  logic [2:0]  applied_internal_freq_select;
  logic [2:0]  next_applied_internal_freq_select;
  logic        startup_timeout_status;
  logic        next_startup_timeout_status;
  logic        evt;
  logic        target_int;
  logic        cur_fall;
  logic        new_rise;
  logic        ost_done;

  assign evt        = boot | wake_from_sleep;
  assign target_int = system_clock_select || (cfg.fosc_mode == FOSC_INT_IO) ||
                      (cfg.fosc_mode == FOSC_INT_CLKOUT);
  assign cur_fall   = applied_int ? int_fall : osc_fall;
  assign new_rise   = target_int ? int_rise : osc_rise;
  assign ost_done   = (state == ST_OST) && osc_rise && (cnt == STARTUP_LAST);

  always_comb begin
    next_state        = state;
    next_cnt          = cnt;
    next_applied_int  = applied_int;
    next_applied_internal_freq_select = applied_internal_freq_select;
    next_startup_timeout_status         = startup_timeout_status;
    // R20 restart on event
    if (evt) begin
      next_cnt          = '0;
      next_applied_int  = target_int;
      next_applied_internal_freq_select = internal_freq_select;
      if (target_int) begin
        // R12 warm-up wait
        next_state = ST_WARM;
      end else if (is_crystal(cfg.fosc_mode)) begin
        // R9 start-up count
        next_state = ST_OST;
      end else begin
        // R13 no start-up delay
        next_state = ST_RUN;
        next_startup_timeout_status  = 1'b1;
      end
    end else begin
      unique case (state)
        ST_RUN: begin
          // R3 running source flag
          next_startup_timeout_status = ~applied_int;
          if (target_int != applied_int || internal_freq_select != applied_internal_freq_select) begin
            next_state = ST_SETTLE;
            next_cnt   = '0;
          end
        end
        ST_SETTLE: begin
          // R11 settle before switch
          next_cnt = cnt + 11'h001;
          if (cnt >= 11'(SETTLE_CYCLES - 1)) begin
            next_state = ST_FALL;
          end
        end
        ST_FALL: begin
          // R18 wait current clock fall
          if (cur_fall) begin
            next_state = ST_RISE;
          end
        end
        ST_RISE: begin
          // R18 wait new clock rise
          if (new_rise) begin
            next_state        = ST_RUN;
            next_applied_int  = target_int;
            next_applied_internal_freq_select = internal_freq_select;
          end
        end
        ST_OST: begin
          // R15 no input edges means the count simply waits
          if (osc_rise) begin
            next_cnt = cnt + 11'h001;
          end
          if (ost_done) begin
            next_state = ST_RUN;
            next_startup_timeout_status  = 1'b1;
          end
        end
        ST_WARM: begin
          next_cnt = cnt + 11'h001;
          if (cnt >= 11'(WARM_CYCLES - 1)) begin
            next_state = ST_RUN;
            next_startup_timeout_status  = 1'b0;
          end
        end
        default: next_state = ST_RUN;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state        <= ST_RUN;
      cnt          <= '0;
      boot         <= 1'b1;
      applied_int  <= 1'b0;
      applied_internal_freq_select <= FREQ_SEL_RESET;
      // R4 start-up flag reset value
      startup_timeout_status         <= !((configuration_word_one.two_speed_start_enable &&
                         is_crystal(configuration_word_one.fosc_mode)) ||
                        configuration_word_one.fail_safe_enable);
    end else begin
      state        <= next_state;
      cnt          <= next_cnt;
      boot         <= 1'b0;
      applied_int  <= next_applied_int;
      applied_internal_freq_select <= next_applied_internal_freq_select;
      startup_timeout_status         <= next_startup_timeout_status;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  logic high_freq_stable;
  logic low_freq_stable;

  // R10 hold during start-up count
  assign exec_hold = ((state == ST_OST) && !ost_done) ||
                     (state == ST_WARM);
  // R18 clock output held low
  assign clk_out_hold_low = (state == ST_RISE);
  // R7 internal clock select
  assign sys_clk_internal = applied_int;
  // R1 frequency decode
  assign postscaler_select = freq_decode(applied_internal_freq_select);
  // R19 fast oscillator enable
  assign fast_internal_oscillator_en =
    (internal_freq_select != FREQ_SEL_SLOW) && (system_clock_select || cfg.two_speed_start_enable);
  assign slow_internal_oscillator_en =
    (internal_freq_select == FREQ_SEL_SLOW) && (system_clock_select || cfg.two_speed_start_enable);
  // R14 second pin freed
  assign oscillator_pin_out_gpio =
    (cfg.fosc_mode == FOSC_EXT_LOGIC) ||
    (cfg.fosc_mode == FOSC_RESCAP_IO) ||
    (cfg.fosc_mode == FOSC_INT_IO);
  // R5 fast stable status
  assign high_freq_stable = lvl[2] & fast_internal_oscillator_en;
  // R6 slow stable status
  assign low_freq_stable = lvl[3] & slow_internal_oscillator_en;

  // R16 gain from crystal mode
  always_comb begin
    unique case (cfg.fosc_mode)
      FOSC_WATCH_XTAL:  amp_gain = GAIN_LOW;
      FOSC_MEDIUM_XTAL: amp_gain = GAIN_MID;
      FOSC_HIGH_XTAL:   amp_gain = GAIN_HIGH;
      default:          amp_gain = GAIN_OFF;
    endcase
  end

  // read data stands one cycle after the strobe
  logic [DATA_W-1:0] next_rdata;
  always_comb begin
    next_rdata = '0;
    if (rd && addr == OSC_CTRL_ADDR) begin
      next_rdata = {1'b0, internal_freq_select, startup_timeout_status, high_freq_stable, low_freq_stable, system_clock_select};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= '0;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence fall_seen_s;
    state == ST_FALL && cur_fall && !evt;
  endsequence
  sequence held_low_s;
    clk_out_hold_low;
  endsequence

  internal_freq_select_reset_a: assert property (disable iff (1'b0) rst |=> internal_freq_select == 3'h6) // R2
    else $error("frequency field not 110 after reset");
  reserved_bit_a: assert property (rd |=> rdata[7] == 1'b0) // R8
    else $error("reserved bit read nonzero");
  status_read_a: assert property (rd && addr == OSC_CTRL_ADDR |=>
    rdata[2:1] == $past({high_freq_stable, low_freq_stable})) // R5
    else $error("stable bits read wrong");
  ost_hold_a: assert property (state == ST_OST && !ost_done |-> exec_hold) // R10
    else $error("execution not held during count");
  ost_release_a: assert property (ost_done && !evt |-> !exec_hold ##1
    state == ST_RUN) // R20
    else $error("hold not released on terminal count");
  ost_restart_a: assert property (wake_from_sleep && !target_int &&
    is_crystal(cfg.fosc_mode) |=> state == ST_OST && cnt == 11'h000) // R9
    else $error("start-up count not restarted");
  ec_nodelay_a: assert property (wake_from_sleep && !target_int &&
    cfg.fosc_mode == FOSC_EXT_LOGIC |=> !exec_hold && startup_timeout_status) // R13
    else $error("external clock mode delayed start");
  switch_low_a: assert property (fall_seen_s |=> held_low_s) // R18
    else $error("clock output not held low after fall");
  gain_high_a: assert property (cfg.fosc_mode == FOSC_HIGH_XTAL |->
    amp_gain == GAIN_HIGH) // R16
    else $error("high gain not selected");
  fast_enable_a: assert property (fast_internal_oscillator_en == ((internal_freq_select !=
    3'h0) && (system_clock_select || cfg.two_speed_start_enable))) // R19
    else $error("fast oscillator enable wrong");

endmodule : soc_osc_ctrl

// File: rtl/soc_pkg.sv
package soc_pkg;

  // ****************************************************************
  // register map and reset values
  // ****************************************************************
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;
  localparam logic [7:0]  OSC_CTRL_ADDR   = 8'h00;
  localparam logic [2:0]  FREQ_SEL_RESET  = 3'h6;
  localparam logic [2:0]  FREQ_SEL_SLOW   = 3'h0;
  localparam logic [2:0]  FREQ_SEL_TOP    = 3'h7;
  localparam int          FREQ_SEL_LSB    = 4;
  localparam int          STARTUP_BIT     = 3;
  localparam int          FAST_STABLE_BIT = 2;
  localparam int          SLOW_STABLE_BIT = 1;
  localparam int          CLK_SEL_BIT     = 0;
  localparam logic        CLK_SEL_RESET   = 1'b0;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int          CLK_PERIOD_NS   = 8;
  localparam int          STARTUP_CYCLES  = 1024;
  localparam logic [10:0] STARTUP_LAST    = 11'(STARTUP_CYCLES - 1);
  localparam int          SWITCH_NS       = 1000;
  localparam int          SWITCH_CYCLES   =
    (SWITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          WARMUP_NS       = 1000;
  localparam int          WARMUP_CYCLES   =
    (WARMUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          SYNC_W          = 4;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0] {
    FOSC_WATCH_XTAL = 3'h0,
    FOSC_MEDIUM_XTAL = 3'h1,
    FOSC_HIGH_XTAL  = 3'h2,
    FOSC_EXT_LOGIC  = 3'h3,
    FOSC_INT_IO     = 3'h4,
    FOSC_INT_CLKOUT = 3'h5,
    FOSC_RESCAP_IO     = 3'h6,
    FOSC_RESCAP_CLKOUT = 3'h7
  } soc_fosc_t;

  typedef enum logic [1:0] {
    GAIN_OFF  = 2'h0,
    GAIN_LOW  = 2'h1,
    GAIN_MID  = 2'h2,
    GAIN_HIGH = 2'h3
  } soc_gain_t;

  typedef struct packed {
    soc_fosc_t fosc_mode;
    logic      two_speed_start_enable;
    logic      fail_safe_enable;
  } soc_cfg_t;

  typedef struct packed {
    logic       slow_select;
    logic [2:0] div_shift;
  } soc_freq_t;

endpackage : soc_pkg

// File: bench/soc_osc_src.sv
`timescale 1ns/10ps

// ****************************************************************
// external clock source and analog oscillator stand-in
// ****************************************************************
module soc_osc_src #(
  parameter real HALF_NS = 24.0,
  parameter real RDY_NS  = 100.0
) (
  // controls from the bench and the block
  input  wire logic run,
  input  wire logic fast_en,
  input  wire logic slow_en,
  // oscillator side
  output logic      pin,
  output logic      phase,
  output wire logic fast_rdy,
  output wire logic slow_rdy
);
  // start both lines low
  initial begin
    pin   = 1'b0;
    phase = 1'b0;
  end

  // crystal or logic clock stands still while run is low
  always begin
    #(HALF_NS);
    if (run) begin
      pin = ~pin;
    end
  end

  // internal oscillator runs free, phase unrelated to clk
  always begin
    #(20.3);
    phase = ~phase;
  end

  // stable flags follow enables after a start-up delay
  assign #(RDY_NS) fast_rdy = fast_en;
  assign #(RDY_NS) slow_rdy = slow_en;
endmodule : soc_osc_src

// File: bench/tb_system_oscillator_control.sv
`timescale 1ns/10ps

module tb_system_oscillator_control
  import soc_pkg::*;
;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic              clk, rst, wr, rd, wake, run, hold_low, sys_int;
  logic              exec_hold, fen, sen, gpio, osc_pin, phase, osc_prev;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, d;
  wire logic         frdy, srdy;
  soc_cfg_t          cfg;
  soc_freq_t         post;
  soc_gain_t         gain;
  logic [31:0]       rnd = 32'hA1F34063;
  int                fails = 0, n_checks = 0, edges = 0, base, n;

  soc_osc_ctrl #(.WARM_CYCLES(20), .SETTLE_CYCLES(2)) soc_osc_ctrl_i (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .configuration_word_one(cfg), .wake_from_sleep(wake),
    .oscillator_pin_in(osc_pin), .int_osc_phase(phase),
    .fast_osc_ready(frdy), .slow_osc_ready(srdy), .exec_hold(exec_hold),
    .clk_out_hold_low(hold_low), .sys_clk_internal(sys_int),
    .postscaler_select(post), .fast_internal_oscillator_en(fen),
    .slow_internal_oscillator_en(sen), .amp_gain(gain),
    .oscillator_pin_out_gpio(gpio));

  soc_osc_src soc_osc_src_i (
    .run(run), .fast_en(fen), .slow_en(sen), .pin(osc_pin),
    .phase(phase), .fast_rdy(frdy), .slow_rdy(srdy));

  // ****************************************************************
  // clock, edge counter and watchdog
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // counts oscillator rises seen while execution is held
  always @(posedge clk) begin
    osc_prev <= osc_pin;
    if (osc_pin && !osc_prev && exec_hold === 1'b1) begin
      edges <= edges + 1;
    end
  end

  // cuts a hang short
  initial begin
    #(8 * 60000);
    fails++;
    stop_test();
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic chk(input string nm, input logic [15:0] e, g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic stop_test();
    if (fails == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  task automatic do_reset(input soc_cfg_t c);
    @(posedge clk);
    rst <= 1'b1;
    cfg <= c;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
  endtask : do_reset

  task automatic wr_reg(input logic [7:0] a, v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rd_reg

  // waits for the hold to drop, counting cycles
  task automatic wait_hold(output int c);
    c = 0;
    while (exec_hold === 1'b1 && c < 40000) begin
      @(posedge clk);
      #1;
      c++;
    end
  endtask : wait_hold

  // waits through one clock switch
  task automatic sw_wait();
    int c;
    c = 0;
    while (hold_low !== 1'b1 && c < 1000) begin
      @(posedge clk);
      #1;
      c++;
    end
    chk("settle_gap", 1, c >= 2);
    while (hold_low === 1'b1 && c < 2000) begin
      @(posedge clk);
      #1;
      c++;
    end
    chk("switch_done", 1, c < 2000);
  endtask : sw_wait

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    rst = 1'b1; wr = 1'b0; rd = 1'b0; wake = 1'b0; run = 1'b1;
    addr = '0; wdata = '0; cfg = '0;
    // crystal modes: gain, start-up count, restart, static hold
    for (int m = 0; m < 3; m++) begin
      do_reset('{soc_fosc_t'(3'(m)), 1'b0, 1'b0});
      chk("gain", 16'(m + 1), 16'(gain));
      chk("pin_free", 0, gpio);
      rd_reg(OSC_CTRL_ADDR, d);
      chk("reset_reg", {1'b0, FREQ_SEL_RESET, 4'h8}, d);
      base = edges;
      if (m == 2) begin
        while (edges - base < 500) @(posedge clk);
        run <= 1'b0;
        repeat (200) @(posedge clk);
        chk("static_hold", 1, exec_hold);
        run  <= 1'b1;
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        base = edges;
      end
      wait_hold(n);
      chk("ost_edges", 1, (edges - base) inside {[1022:1026]});
      rd_reg(OSC_CTRL_ADDR, d);
      chk("after_ost", {1'b0, FREQ_SEL_RESET, 4'h8}, d);
    end
    // two-speed with crystal clears the status bit at reset
    do_reset('{FOSC_MEDIUM_XTAL, 1'b1, 1'b0});
    rd_reg(OSC_CTRL_ADDR, d);
    chk("startup_two_speed", 0, d[STARTUP_BIT]);
    // internal target waits the warm-up count
    do_reset('{FOSC_INT_IO, 1'b0, 1'b0});
    wait_hold(n);
    chk("warm_cycles", 1, n inside {[19:21]});
    // logic clock: no hold, second pin free
    do_reset('{FOSC_EXT_LOGIC, 1'b0, 1'b0});
    chk("ec_no_hold", 0, exec_hold);
    chk("ec_pin_free", 1, gpio);
    // every frequency code with internal select, random filler bits
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      wr_reg(OSC_CTRL_ADDR, {rnd[7], 3'(i), rnd[3:1], 1'b1});
      sw_wait();
      chk("sys_int", 1, sys_int);
      chk("slow_sel", 16'(i == 0), post.slow_select);
      if (i != 0) chk("div_shift", 16'(7 - i), post.div_shift);
      chk("fast_en", 16'(i != 0), fen);
      chk("slow_en", 16'(i == 0), sen);
      repeat (40) @(posedge clk);
      rd_reg(OSC_CTRL_ADDR, d);
      chk("reg_int", {1'b0, 3'(i), 1'b0, i != 0, i == 0, 1'b1}, d);
    end
    // back to the configured source
    wr_reg(OSC_CTRL_ADDR, 8'h60);
    sw_wait();
    chk("sys_ext", 0, sys_int);
    repeat (40) @(posedge clk);
    rd_reg(OSC_CTRL_ADDR, d);
    chk("reg_ext", 8'h68, d);
    // unmapped place: ignored write, zero read, data stands one cycle
    wr_reg(8'h05, 8'hFF);
    rd_reg(8'h05, d);
    chk("unmapped", 0, d);
    rd_reg(OSC_CTRL_ADDR, d);
    @(posedge clk);
    #1;
    chk("rdata_drop", 0, rdata);
    chk("reg_kept", 8'h68, d);
    stop_test();
  end
endmodule : tb_system_oscillator_control
